// File: logic/rtil_pkg.sv
// package: constants, types and register map of the range teach input logic
package rtil_pkg;

    // ==========================================================
    // position and code widths
    localparam int POS_W = 27;
    localparam int REV_W = 15;
    localparam int ANG_W = 12;
    localparam int CODE_W = 12;
    localparam int DIVD_W = POS_W + CODE_W;

    // ==========================================================
    // factory range: ten turns centred in the full span
    localparam logic [POS_W-1:0] DEF_SPAN = 27'h000a000;
    localparam logic [POS_W-1:0] DEF_ZERO = 27'h3ffb000;
    localparam logic [POS_W-1:0] HALF_SPAN = 27'h4000000;
    localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;
    localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int HOLD_TIME_MS = 1500;
    localparam int SKEW_TIME_US = 1000;
    localparam int HOLD_CYC = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int SKEW_CYC = SKEW_TIME_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 32;

    // ==========================================================
    // register map, byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ZERO = 8'h04;
    localparam logic [7:0] OFS_SPAN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CODE = 8'h10;
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_TEACH_EN_BIT = 1;
    localparam logic CTRL_TEACH_EN_RST = 1'b1;

    // ==========================================================
    // types
    typedef enum logic {
        clockwise_increasing,
        counterclockwise_increasing
    } rtil_dir_e;

    typedef struct packed {
        rtil_dir_e dir;
        logic [POS_W-1:0] zero;
        logic [POS_W-1:0] span;
    } rtil_cfg_s;

    typedef enum {
        CMD_NONE,
        CMD_ZERO,
        CMD_FINAL,
        CMD_DEFAULT
    } rtil_cmd_e;

    typedef enum {
        RGN_INSIDE,
        RGN_OVER,
        RGN_UNDER
    } rtil_region_e;

    typedef enum {
        CV_IDLE,
        CV_DIVIDE
    } rtil_conv_e;

    localparam rtil_cfg_s CFG_DEFAULT = '{dir: clockwise_increasing, zero: DEF_ZERO, span: DEF_SPAN};

endpackage : rtil_pkg

// File: logic/rtil_div.sv
// sequential divider: quotient of a scaled position over the range span
`timescale 1ns/1ps
`default_nettype none
module rtil_div
    import rtil_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // request
    input wire logic start,
    input wire logic [DIVD_W-1:0] dividend,
    input wire logic [POS_W-1:0] divisor,
    // answer
    output logic done,
    output logic [CODE_W-1:0] quotient
);

    // ==========================================================
    // long division, one quotient bit per cycle
    logic [POS_W:0] rem_reg;
    logic [CODE_W-1:0] low_reg;
    logic [3:0] step_reg;
    logic busy_reg;
    logic [POS_W:0] trial;

    // trial remainder with next dividend bit shifted in
    always_comb begin
        trial = {rem_reg[POS_W-1:0], low_reg[CODE_W-1]};
    end

    // iteration; high part is below the divisor so twelve steps suffice
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rem_reg <= '0;
            low_reg <= '0;
            step_reg <= '0;
            busy_reg <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy_reg) begin
                rem_reg <= {1'b0, dividend[DIVD_W-1:CODE_W]};
                low_reg <= dividend[CODE_W-1:0];
                step_reg <= 4'(CODE_W);
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                low_reg <= {low_reg[CODE_W-2:0], 1'b0};
                if (trial >= {1'b0, divisor}) begin
                    rem_reg <= trial - {1'b0, divisor};
                    quotient <= {quotient[CODE_W-2:0], 1'b1};
                end else begin
                    rem_reg <= trial;
                    quotient <= {quotient[CODE_W-2:0], 1'b0};
                end
                step_reg <= step_reg - 4'h1;
                if (step_reg == 4'h1) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule : rtil_div
`default_nettype wire

// File: logic/rtil_top.sv
// range teach input logic: position scaling, clamping and teach input decoding
//
// Overview of operation
// - position spans fifteen bits of turns, 32768 revolutions, range anywhere inside
// - factory range is ten turns, values increasing clockwise
// - outside the range, overflow above and underflow below split the rest equally
// - in overflow the code holds full scale instead of wrapping
// - zero point can be taught at any position, even in overflow or underflow
// - direction, zero, end and factory default are set with two teach inputs only
// - A low, B high for 1.5 s stores present position as zero point
// - B low, A high for 1.5 s stores present position as final value
// - both low within 1 ms, held 1.5 s, restores factory range and direction
// - zero teach then final teach at same position reverses count direction
// - both inputs high: normal conversion with stored settings
// - scaled position leaves as a twelve-bit code for the converter
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rtil_top
    import rtil_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int SKEW_CYCLES = SKEW_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // position source
    input wire logic [POS_W-1:0] position,
    // teach pins, active low
    input wire logic teach_a_n,
    input wire logic teach_b_n,
    // non-volatile settings store
    input wire logic nv_restore,
    input wire rtil_cfg_s nv_cfg_in,
    output logic nv_save,
    output rtil_cfg_s nv_cfg_out,
    // converter
    output logic [CODE_W-1:0] dac_code,
    output logic dac_load
);

    // ==========================================================
    // helpers
    function automatic logic [POS_W-1:0] rel_pos(input rtil_cfg_s c, input logic [POS_W-1:0] p);
        if (c.dir == clockwise_increasing) begin
            rel_pos = p - c.zero;
        end else begin
            rel_pos = c.zero - p;
        end
    endfunction : rel_pos

    function automatic logic apb_addr_ok(input logic [7:0] a);
        apb_addr_ok = (a == OFS_CTRL) || (a == OFS_ZERO) || (a == OFS_SPAN) || (a == OFS_STATUS) || (a == OFS_CODE);
    endfunction : apb_addr_ok

    // ==========================================================
    // teach pin synchronisers
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;

    // two stages, first read only by the second
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
        end else begin
            pin_meta_reg <= {~teach_b_n, ~teach_a_n};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ==========================================================
    // teach pattern timing
    logic [1:0] pat_reg;
    logic [CNT_W-1:0] hold_cnt_reg;
    logic skew_ok_reg;
    logic fired_reg;
    logic teach_en_reg;
    rtil_cmd_e cmd_next;
    rtil_cmd_e cmd_reg;
    logic hold_hit;

    assign hold_hit = hold_cnt_reg == CNT_W'(HOLD_CYCLES - 1);

    // counter restarts on any pattern change, so a short hold is dropped
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pat_reg <= 2'h0;
            hold_cnt_reg <= '0;
            skew_ok_reg <= 1'b0;
            fired_reg <= 1'b0;
        end else if (pin_sync_reg != pat_reg) begin
            pat_reg <= pin_sync_reg;
            hold_cnt_reg <= '0;
            fired_reg <= 1'b0;
            if (pin_sync_reg == 2'h3) begin
                skew_ok_reg <= (pat_reg == 2'h0) || (hold_cnt_reg < CNT_W'(SKEW_CYCLES));
            end
        end else begin
            if (!hold_hit) begin
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
            if (cmd_next != CMD_NONE) begin
                fired_reg <= 1'b1;
            end
        end
    end

    // pattern decode once the full hold has passed
    always_comb begin
        cmd_next = CMD_NONE;
        if (hold_hit && !fired_reg && teach_en_reg && (pin_sync_reg == pat_reg)) begin
            if (pat_reg == 2'h1) begin
                cmd_next = CMD_ZERO;
            end else if (pat_reg == 2'h2) begin
                cmd_next = CMD_FINAL;
            end else if (pat_reg == 2'h3 && skew_ok_reg) begin
                cmd_next = CMD_DEFAULT;
            end
        end
    end

    // one-cycle command pulse
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_reg <= CMD_NONE;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    // ==========================================================
    // settings store
    rtil_cfg_s cfg_reg;
    logic zero_taught_reg;
    logic [POS_W-1:0] rel_now;
    logic apb_wr;
    logic apb_rd;
    logic save_pend_reg;

    assign rel_now = rel_pos(cfg_reg, position);
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_rd = psel && penable && !pready && !pwrite;

    // teach commands win over software writes in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= CFG_DEFAULT;
            zero_taught_reg <= 1'b0;
        end else if (cmd_reg == CMD_ZERO) begin
            cfg_reg.zero <= position;
            zero_taught_reg <= 1'b1;
        end else if (cmd_reg == CMD_FINAL) begin
            zero_taught_reg <= 1'b0;
            if (zero_taught_reg && position == cfg_reg.zero) begin
                cfg_reg.dir <= (cfg_reg.dir == clockwise_increasing) ? counterclockwise_increasing
                               : clockwise_increasing;
            end else begin
                cfg_reg.span <= rel_now;
            end
        end else if (cmd_reg == CMD_DEFAULT) begin
            cfg_reg <= CFG_DEFAULT;
            zero_taught_reg <= 1'b0;
        end else if (nv_restore) begin
            cfg_reg <= nv_cfg_in;
        end else if (apb_wr) begin
            if (paddr == OFS_CTRL) begin
                cfg_reg.dir <= rtil_dir_e'(pwdata[CTRL_DIR_BIT]);
            end else if (paddr == OFS_ZERO) begin
                cfg_reg.zero <= pwdata[POS_W-1:0];
            end else if (paddr == OFS_SPAN) begin
                cfg_reg.span <= pwdata[POS_W-1:0];
            end
        end
    end

    // teach enable bit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            teach_en_reg <= CTRL_TEACH_EN_RST;
        end else if (apb_wr && paddr == OFS_CTRL) begin
            teach_en_reg <= pwdata[CTRL_TEACH_EN_BIT];
        end
    end

    // offer every taught change to the non-volatile store; strobe waits one cycle so the copy is fresh
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            save_pend_reg <= 1'b0;
            nv_save <= 1'b0;
            nv_cfg_out <= CFG_DEFAULT;
        end else begin
            save_pend_reg <= cmd_reg != CMD_NONE;
            nv_save <= save_pend_reg;
            nv_cfg_out <= cfg_reg;
        end
    end

    // ==========================================================
    // conversion
    rtil_conv_e conv_reg;
    rtil_region_e region_reg;
    rtil_region_e region_next;
    logic [POS_W-1:0] span_reg;
    logic div_start;
    logic div_done;
    logic [CODE_W-1:0] div_q;
    logic [DIVD_W-1:0] div_num;

    // region split: beyond the span, lower half of the rest is overflow
    always_comb begin
        if (rel_now < cfg_reg.span) begin
            region_next = RGN_INSIDE;
        end else if ((rel_now - cfg_reg.span) < (HALF_SPAN - (cfg_reg.span >> 1))) begin
            region_next = RGN_OVER;
        end else begin
            region_next = RGN_UNDER;
        end
    end

    assign div_start = (conv_reg == CV_IDLE) && (region_next == RGN_INSIDE);
    assign div_num = ({{CODE_W{1'b0}}, rel_now} << CODE_W) - {{CODE_W{1'b0}}, rel_now};

    rtil_div u_div (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(div_start),
        .dividend(div_num),
        .divisor(span_reg), // span frozen while dividing
        .done(div_done),
        .quotient(div_q)
    );

    // continuous sampling: clamp at once, divide when inside
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conv_reg <= CV_IDLE;
            region_reg <= RGN_UNDER;
            span_reg <= DEF_SPAN;
            dac_code <= CODE_MIN;
            dac_load <= 1'b0;
        end else begin
            dac_load <= 1'b0;
            case (conv_reg)
                CV_IDLE: begin
                    region_reg <= region_next;
                    span_reg <= cfg_reg.span;
                    if (region_next == RGN_OVER) begin
                        dac_code <= CODE_MAX;
                        dac_load <= 1'b1;
                    end else if (region_next == RGN_UNDER) begin
                        dac_code <= CODE_MIN;
                        dac_load <= 1'b1;
                    end else begin
                        conv_reg <= CV_DIVIDE;
                    end
                end
                CV_DIVIDE: begin
                    if (div_done) begin
                        dac_code <= div_q;
                        dac_load <= 1'b1;
                        conv_reg <= CV_IDLE;
                    end
                end
                default: begin
                    conv_reg <= CV_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // apb slave: one wait state, reads latched at the first access cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !apb_addr_ok(paddr);
            if (apb_rd) begin
                if (paddr == OFS_CTRL) begin
                    prdata <= {30'h0, teach_en_reg, cfg_reg.dir};
                end else if (paddr == OFS_ZERO) begin
                    prdata <= {5'h0, cfg_reg.zero};
                end else if (paddr == OFS_SPAN) begin
                    prdata <= {5'h0, cfg_reg.span};
                end else if (paddr == OFS_STATUS) begin
                    prdata <= {24'h0, zero_taught_reg, pat_reg, conv_reg == CV_DIVIDE,
                               region_reg == RGN_UNDER, region_reg == RGN_OVER, fired_reg, 1'b0};
                end else if (paddr == OFS_CODE) begin
                    prdata <= {20'h0, dac_code};
                end else begin
                    prdata <= '0;
                end
            end
        end
    end

endmodule : rtil_top
`default_nettype wire

// File: sim/rtil_top_sva.sv
// checker: port-level properties of the range teach input logic
`timescale 1ns/1ps
`default_nettype none
module rtil_top_sva
    import rtil_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // teach pins and settings store
    input wire logic teach_a_n,
    input wire logic teach_b_n,
    input wire logic nv_save
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // helper: cycles the raw pin pattern has stood active and unchanged
    logic [1:0] pat_reg;
    logic [31:0] held_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pat_reg <= 2'h3;
            held_reg <= '0;
        end else begin
            pat_reg <= {teach_a_n, teach_b_n};
            if ((teach_a_n && teach_b_n) || ({teach_a_n, teach_b_n} != pat_reg)) begin
                held_reg <= '0;
            end else begin
                held_reg <= held_reg + 32'h1;
            end
        end
    end

    // ==========================================================
    // apb answer timing
    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
    property p_one_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not one cycle after access");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    property p_err_read_zero;
        pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_err_read_zero: assert property (p_err_read_zero) else $error("refused read returned data");

    // ==========================================================
    // teach commands
    property p_save_pulse;
        nv_save |=> !nv_save;
    endproperty
    a_save_pulse: assert property (p_save_pulse) else $error("save strobe longer than one cycle");
    property p_save_after_hold;
        nv_save |-> held_reg >= HOLD_CYCLES;
    endproperty
    a_save_after_hold: assert property (p_save_after_hold) else $error("command before hold time");
    property p_idle_quiet;
        (teach_a_n && teach_b_n) [*8] |-> !nv_save;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("command with pins idle");

    // ==========================================================
    // main scenarios seen
    c_save: cover property (nv_save);
    c_refused: cover property (pslverr);
    c_write: cover property (pready && pwrite);
endmodule : rtil_top_sva
`default_nettype wire

// File: sim/rtil_teach_sw.sv
// partner: operator switches on the two teach pins
`timescale 1ns/1ps
`default_nettype none
module rtil_teach_sw (
    // clock
    input wire logic ref_clk,
    // operator request and lag of pin b
    input wire logic press_a,
    input wire logic press_b,
    input wire logic [7:0] skew,
    // teach pins, active low
    output logic teach_a_n,
    output logic teach_b_n
);
    logic [7:0] lag_reg;
    // pin a follows the operator at once
    always_ff @(posedge ref_clk) begin
        teach_a_n <= !press_a;
    end
    // pin b falls a set number of cycles after the request
    always_ff @(posedge ref_clk) begin
        if (!press_b) begin
            lag_reg <= 8'h00;
            teach_b_n <= 1'b1;
        end else if (lag_reg >= skew) begin
            teach_b_n <= 1'b0;
        end else begin
            lag_reg <= lag_reg + 8'h01;
        end
    end
endmodule : rtil_teach_sw
`default_nettype wire

// File: sim/rtil_top_tb.sv
// testbench: conversion table, teach patterns and register access
`timescale 1ns/1ps
`default_nettype none
module rtil_top_tb
    import rtil_pkg::*;
;
    localparam int HOLD = 200;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, nv_restore, nv_save, dac_load;
    logic teach_a_n, teach_b_n, press_a, press_b, s, er;
    logic [7:0] paddr, skew;
    logic [31:0] pwdata, prdata, rd;
    logic [POS_W-1:0] position;
    logic [CODE_W-1:0] dac_code;
    rtil_cfg_s nv_cfg_in, nv_cfg_out, saved;
    int n_mismatch, n_tests;
    // position beside expected code, default range
    logic [38:0] rows [7] = '{{27'h3ffb000, 12'h000}, {27'h4000000, 12'h7ff}, {27'h4004fff, 12'hffe},
        {27'h4005000, 12'hfff}, {27'h3ffafff, 12'h000}, {27'h7ffffff, 12'hfff}, {27'h0000000, 12'h000}};

    rtil_top #(.HOLD_CYCLES(HOLD), .SKEW_CYCLES(20)) i_rtil_top (.ref_clk(ref_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .position(position), .teach_a_n(teach_a_n),
        .teach_b_n(teach_b_n), .nv_restore(nv_restore), .nv_cfg_in(nv_cfg_in), .nv_save(nv_save),
        .nv_cfg_out(nv_cfg_out), .dac_code(dac_code), .dac_load(dac_load));
    rtil_teach_sw i_rtil_teach_sw (.ref_clk(ref_clk), .press_a(press_a), .press_b(press_b),
        .skew(skew), .teach_a_n(teach_a_n), .teach_b_n(teach_b_n));

    // ==========================================================
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) begin
            @(posedge ref_clk);
        end
        if (i == 20) begin
            n_mismatch++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input logic [POS_W-1:0] p);
        @(posedge ref_clk);
        position <= p;
        repeat (40) @(posedge ref_clk);
    endtask : settle
    task automatic teach(input logic a, input logic b, input logic [7:0] sk, input int hold);
        int i;
        s = 1'b0;
        @(posedge ref_clk);
        press_a <= a;
        press_b <= b;
        skew <= sk;
        for (i = 0; i < HOLD + 60 && !s; i++) begin
            @(posedge ref_clk);
            s = (nv_save === 1'b1);
            saved = nv_cfg_out;
            if (i == hold) begin
                press_a <= 1'b0;
                press_b <= 1'b0;
            end
        end
        press_a <= 1'b0;
        press_b <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask : teach

    // ==========================================================
    // main sequence
    initial begin
        {nrst, psel, penable, pwrite, press_a, press_b, nv_restore} = '0;
        {paddr, skew, pwdata, n_mismatch, n_tests} = '0;
        position = DEF_ZERO;
        nv_cfg_in = CFG_DEFAULT;
        repeat (12) @(posedge ref_clk);
        chk(nv_cfg_out, CFG_DEFAULT);
        nrst <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h2);
        $display("reset test done");
        foreach (rows[k]) begin
            settle(rows[k][38:12]);
            chk(dac_code, rows[k][11:0]);
            apb(1'b0, OFS_CODE, 32'h0);
            chk(rd, {20'h0, rows[k][11:0]});
        end
        $display("table test done");
        settle(27'h5000000);
        teach(1'b1, 1'b0, 8'h00, 9999);
        chk(s, 1'b1);
        chk(nv_cfg_out.zero, 27'h5000000);
        chk(saved.zero, 27'h5000000);
        settle(27'h5003000);
        teach(1'b0, 1'b1, 8'h00, 9999);
        chk(nv_cfg_out.span, 27'h0003000);
        chk(saved.span, 27'h0003000);
        settle(27'h5001800);
        chk(dac_code, 12'h7ff);
        settle(27'h5004000);
        chk(dac_code, 12'hfff);
        chk(dac_load, 1'b1);
        teach(1'b1, 1'b0, 8'h00, 100);
        chk(s, 1'b0);
        chk(nv_cfg_out.zero, 27'h5000000);
        $display("teach test done");
        settle(27'h2000000);
        teach(1'b1, 1'b0, 8'h00, 9999);
        teach(1'b0, 1'b1, 8'h00, 9999);
        chk(nv_cfg_out, {counterclockwise_increasing, 27'h2000000, 27'h0003000});
        settle(27'h1ffe800);
        chk(dac_code, 12'h7ff);
        teach(1'b1, 1'b1, 8'h05, 9999);
        chk(nv_cfg_out, CFG_DEFAULT);
        teach(1'b1, 1'b1, 8'h28, 9999);
        chk(s, 1'b0);
        $display("direction and default test done");
        @(posedge ref_clk);
        nv_cfg_in <= '{counterclockwise_increasing, 27'h1234000, 27'h0001000};
        nv_restore <= 1'b1;
        @(posedge ref_clk);
        nv_restore <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(nv_cfg_out, {counterclockwise_increasing, 27'h1234000, 27'h0001000});
        apb(1'b1, OFS_ZERO, 32'h0100000);
        apb(1'b0, OFS_ZERO, 32'h0);
        chk(rd, 32'h0100000);
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, OFS_CTRL, 32'h0);
        teach(1'b1, 1'b0, 8'h00, 9999);
        chk(s, 1'b0);
        $display("register and store test done");
        give_verdict();
    end
endmodule : rtil_top_tb

bind rtil_top rtil_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_rtil_top_sva (.ref_clk(ref_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .teach_a_n(teach_a_n), .teach_b_n(teach_b_n), .nv_save(nv_save));
`default_nettype wire
